/* File: verilog/auto_test_pkg.sv */
package auto_test_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int SEQ_COUNT = 8;            // sequence slots
   localparam int STEP_MAX = 50;            // steps per slot
   localparam int STEP_MIN = 1;             // fewest steps per slot
   localparam int VAL_W = 16;               // setpoint and limit width

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 200_000_000;     // system clock rate
   localparam int TICK_MS = 100;            // delay resolution in ms
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int START_LOW_MS = 5;         // least trigger-low time in ms
   localparam int START_LOW_CYCLES = CLK_HZ / 1000 * START_LOW_MS;
   localparam int PULSE_S = 5;              // timed output length in s
   localparam int PULSE_TICKS = PULSE_S * 1000 / TICK_MS;
   localparam logic [7:0] DELAY_MIN = 8'h01;       // 0.1 s
   localparam logic [7:0] DELAY_SUSPEND = 8'hFF;   // 25.5 s means suspend

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic RESULT_OUT_RST = 1'b0;

   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_INPUT_OFF,
      MODE_CONSTANT_CURRENT,
      MODE_CONSTANT_VOLTAGE,
      MODE_CONSTANT_POWER,
      MODE_CONSTANT_RESISTANCE,
      MODE_SHORT_CIRCUIT
   } step_mode_type;

   typedef enum logic [1:0] {
      CMP_CURRENT,
      CMP_VOLTAGE,
      CMP_POWER,
      CMP_RESISTANCE
   } cmp_kind_type;

   typedef enum logic [1:0] {
      FIRE_ON_PASS,
      FIRE_ON_FAIL,
      FIRE_ON_END,
      FIRE_NEVER
   } fire_cond_type;

   // one stored step
   typedef struct packed {
      step_mode_type mode;
      cmp_kind_type kind;
      logic [7:0] delay;
      logic [VAL_W-1:0] setpoint;
      logic [VAL_W-1:0] lower;
      logic [VAL_W-1:0] upper;
   } step_type;

   // measurements from the load stage
   typedef struct packed {
      logic [VAL_W-1:0] current;
      logic [VAL_W-1:0] voltage;
      logic [VAL_W-1:0] power;
      logic [VAL_W-1:0] resistance;
   } meas_type;

   // operating condition applied to the load stage
   typedef struct packed {
      step_mode_type mode;
      logic [VAL_W-1:0] setpoint;
   } apply_type;

endpackage

/* File: verilog/auto_test_step_sequencer.sv */
// Functional notes
// [RL1] eight slots, fifty steps each
// [RL2] step count 1..50, others rejected
// [RL3] six operating modes per step
// [RL4] regulated steps pick one of four quantities
// [RL5] input-off step compares voltage only
// [RL6] short-circuit step compares current only
// [RL7] settling delay 0.1..25.5 s before compare
// [RL8] 25.5 s delay suspends until trigger
// [RL9] resume on rear input, trigger key, on/off
// [RL10] regulated step applies its stored setpoint
// [RL11] pass only inside lower and upper limits
// [RL12] report verdict; fail sounds alarm
// [RL13] output fires on pass, fail, end, never
// [RL14] level style held until key or trigger
// [RL15] timed style drops after five seconds
// [RL16] start on on/off or qualified 5 ms low
// [RL17] waiting and suspended shown separately
// [RL18] verdict cleared by trigger or any key
// [RL19] up/down after end steps manually
// [RL20] on/off or trigger restarts from step one
// [RL21] list redefinition erases the slot
// [RL22] any failing step fails the sequence
// [RL23] delay counted in 100 ms ticks
`timescale 1ns/1ps
module auto_test_step_sequencer #(
   parameter int SEQ_COUNT = auto_test_pkg::SEQ_COUNT,
   parameter int STEP_MAX = auto_test_pkg::STEP_MAX,
   parameter int TICK_CYCLES = auto_test_pkg::TICK_CYCLES,
   parameter int START_LOW_CYCLES = auto_test_pkg::START_LOW_CYCLES
) (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RESET_N_I,
   // step programming port
   input wire logic PROG_WE_I,
   input wire logic [2:0] PROG_SLOT_I,
   input wire logic [5:0] PROG_STEP_I,
   input wire auto_test_pkg::step_type PROG_DATA_I,
   input wire logic LEN_WE_I,
   input wire logic [5:0] LEN_VALUE_I,
   input wire logic LIST_DEFINE_I,
   output logic LEN_REJECT_O,
   // run configuration
   input wire logic [2:0] LOAD_SLOT_I,
   input wire logic LOAD_I,
   input wire auto_test_pkg::fire_cond_type FIRE_COND_I,
   input wire logic TIMED_OUTPUT_STYLE_I,
   // operator keys, one-cycle pulses
   input wire logic KEY_ONOFF_I,
   input wire logic KEY_TRIGGER_I,
   input wire logic KEY_UP_I,
   input wire logic KEY_DOWN_I,
   input wire logic KEY_OTHER_I,
   // rear trigger input, active low
   input wire logic EXTERNAL_START_INPUT_N_I,
   // measurements
   input wire auto_test_pkg::meas_type MEAS_I,
   // load stage control and status
   output auto_test_pkg::apply_type APPLY_O,
   output logic LOADED_SEQUENCE_INDICATOR_O,
   output logic WAITING_STATUS_O,
   output logic SUSPENDED_STATUS_O,
   output logic MANUAL_STATUS_O,
   output logic PASS_O,
   output logic FAIL_O,
   output logic ALARM_O,
   output logic RESULT_SIGNAL_OUTPUT_O
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------

   // choose the measurement a step compares
   function automatic logic [auto_test_pkg::VAL_W-1:0] pick_meas(input auto_test_pkg::step_type s,
                                                                 input auto_test_pkg::meas_type m);
      if (s.mode == auto_test_pkg::MODE_INPUT_OFF) begin
         pick_meas = m.voltage; // see [RL5]
      end else if (s.mode == auto_test_pkg::MODE_SHORT_CIRCUIT) begin
         pick_meas = m.current; // see [RL6]
      end else begin
         case (s.kind) // see [RL4]
            auto_test_pkg::CMP_CURRENT: pick_meas = m.current;
            auto_test_pkg::CMP_VOLTAGE: pick_meas = m.voltage;
            auto_test_pkg::CMP_POWER: pick_meas = m.power;
            default: pick_meas = m.resistance;
         endcase
      end
   endfunction

   // operating condition driven for a step
   function automatic auto_test_pkg::apply_type step_apply(input auto_test_pkg::step_type s);
      step_apply.mode = s.mode; // see [RL3]
      if (s.mode == auto_test_pkg::MODE_INPUT_OFF || s.mode == auto_test_pkg::MODE_SHORT_CIRCUIT) begin
         step_apply.setpoint = '0;
      end else begin
         step_apply.setpoint = s.setpoint; // see [RL10]
      end
   endfunction

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   auto_test_pkg::step_type step_mem [SEQ_COUNT*STEP_MAX]; // all steps of all slots
   logic [5:0] len_reg [SEQ_COUNT]; // step count per slot, 0 = empty
   logic [2:0] slot_reg; // loaded slot
   logic loaded_reg; // a valid sequence is loaded

   typedef enum {ST_IDLE, ST_RUN, ST_SUSPEND, ST_DONE, ST_MANUAL} seq_state_type;
   seq_state_type state_reg;
   logic [5:0] step_reg; // current step index
   logic [7:0] tick_cnt_reg; // elapsed 100 ms ticks in step
   logic [31:0] cyc_cnt_reg; // cycles within a tick
   logic fail_seen_reg; // a step failed during this run
   logic [31:0] low_cnt_reg; // trigger low time
   logic ext_trig_reg; // qualified rear trigger, one cycle
   logic [7:0] pulse_cnt_reg; // ticks the timed output has been high

   auto_test_pkg::step_type cur_step;
   logic tick;
   logic trig_any;
   logic last_step;
   logic step_pass;
   logic step_start; // a step is entered by a start or a resume

   assign cur_step = step_mem[int'(slot_reg) * STEP_MAX + int'(step_reg)];
   assign tick = (cyc_cnt_reg == 32'(TICK_CYCLES - 1));
   assign trig_any = ext_trig_reg || KEY_TRIGGER_I || KEY_ONOFF_I; // see [RL9]
   assign last_step = (step_reg == len_reg[slot_reg] - 6'h01);
   assign step_pass = (pick_meas(cur_step, MEAS_I) >= cur_step.lower)
                      && (pick_meas(cur_step, MEAS_I) <= cur_step.upper); // see [RL11]
   // the tick base restarts on step entry, so a first tick is never short;
   // a timed output running meanwhile stretches by less than one tick
   assign step_start = ((state_reg == ST_IDLE || state_reg == ST_DONE || state_reg == ST_MANUAL)
                        && loaded_reg && (ext_trig_reg || KEY_ONOFF_I))
                       || (state_reg == ST_SUSPEND && trig_any);

   // ----------------------------------------------------------------
   // programming
   // ----------------------------------------------------------------

   // step writes; contents are not cleared on reset, the count gates them
   always_ff @(posedge SYS_CLK_I) begin
      if (PROG_WE_I && int'(PROG_STEP_I) < STEP_MAX) begin // see [RL1]
         step_mem[int'(PROG_SLOT_I) * STEP_MAX + int'(PROG_STEP_I)] <= PROG_DATA_I;
      end
   end

   // step counts; a list redefinition empties the slot until a new count is written
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         for (int i = 0; i < SEQ_COUNT; i++) begin
            len_reg[i] <= 6'h00;
         end
         LEN_REJECT_O <= 1'b0;
      end else begin
         LEN_REJECT_O <= 1'b0;
         if (LIST_DEFINE_I) begin
            len_reg[PROG_SLOT_I] <= 6'h00; // see [RL21]
         end else if (LEN_WE_I) begin
            if (LEN_VALUE_I >= 6'(auto_test_pkg::STEP_MIN) && int'(LEN_VALUE_I) <= STEP_MAX) begin
               len_reg[PROG_SLOT_I] <= LEN_VALUE_I; // see [RL2]
            end else begin
               LEN_REJECT_O <= 1'b1; // see [RL2]
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // rear trigger qualification
   // ----------------------------------------------------------------

   // fires once when the line has been low for the full window
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         low_cnt_reg <= 32'h0000_0000;
         ext_trig_reg <= 1'b0;
      end else begin
         ext_trig_reg <= 1'b0;
         if (EXTERNAL_START_INPUT_N_I) begin
            low_cnt_reg <= 32'h0000_0000;
         end else if (low_cnt_reg < 32'(START_LOW_CYCLES)) begin
            low_cnt_reg <= low_cnt_reg + 32'h0000_0001;
            if (low_cnt_reg == 32'(START_LOW_CYCLES - 1)) begin
               ext_trig_reg <= 1'b1; // see [RL16]
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // 100 ms tick base
   // ----------------------------------------------------------------
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I || tick || step_start) begin // see [RL23]
         cyc_cnt_reg <= 32'h0000_0000;
      end else begin
         cyc_cnt_reg <= cyc_cnt_reg + 32'h0000_0001;
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------

   // loaded slot; loading an empty slot leaves nothing runnable
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         slot_reg <= 3'h0;
         loaded_reg <= 1'b0;
      end else if (LOAD_I && state_reg != ST_RUN && state_reg != ST_SUSPEND) begin
         slot_reg <= LOAD_SLOT_I;
         loaded_reg <= (len_reg[LOAD_SLOT_I] != 6'h00);
      end else if (len_reg[slot_reg] == 6'h00) begin
         loaded_reg <= 1'b0; // slot erased under us
      end
   end

   // step walk, delay count and verdict collection
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         state_reg <= ST_IDLE;
         step_reg <= 6'h00;
         tick_cnt_reg <= 8'h00;
         fail_seen_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE, ST_DONE, ST_MANUAL: begin
               if (loaded_reg && (ext_trig_reg || KEY_ONOFF_I)) begin
                  state_reg <= ST_RUN; // see [RL16] [RL20]
                  step_reg <= 6'h00;
                  tick_cnt_reg <= 8'h00;
                  fail_seen_reg <= 1'b0;
               end else if (state_reg != ST_IDLE && KEY_UP_I) begin
                  state_reg <= ST_MANUAL; // see [RL19]
                  step_reg <= (step_reg == 6'h00) ? step_reg : step_reg - 6'h01;
               end else if (state_reg != ST_IDLE && KEY_DOWN_I) begin
                  state_reg <= ST_MANUAL; // see [RL19]
                  step_reg <= last_step ? step_reg : step_reg + 6'h01;
               end
            end
            ST_RUN: begin
               if (!loaded_reg) begin
                  state_reg <= ST_IDLE;
               end else if (cur_step.delay == auto_test_pkg::DELAY_SUSPEND) begin
                  state_reg <= ST_SUSPEND; // see [RL8]
               end else if (tick) begin
                  // a delay below the least value still waits one tick
                  if (tick_cnt_reg + 8'h01 >= cur_step.delay) begin // see [RL7] [RL23]
                     tick_cnt_reg <= 8'h00;
                     if (!step_pass) begin
                        fail_seen_reg <= 1'b1; // see [RL22]
                     end
                     if (last_step) begin
                        state_reg <= ST_DONE;
                     end else begin
                        step_reg <= step_reg + 6'h01;
                     end
                  end else begin
                     tick_cnt_reg <= tick_cnt_reg + 8'h01; // see [RL23]
                  end
               end
            end
            ST_SUSPEND: begin
               // the suspended step advances without a compare
               if (trig_any) begin // see [RL9]
                  tick_cnt_reg <= 8'h00;
                  if (last_step) begin
                     state_reg <= ST_DONE;
                  end else begin
                     state_reg <= ST_RUN;
                     step_reg <= step_reg + 6'h01;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic done_now; // run finishes on this edge
   logic verdict_fail; // verdict of that run
   logic fire_now; // result signal fires
   logic any_key;

   assign done_now = (state_reg == ST_RUN && tick && last_step && cur_step.delay != auto_test_pkg::DELAY_SUSPEND
                      && tick_cnt_reg + 8'h01 >= cur_step.delay)
                     || (state_reg == ST_SUSPEND && trig_any && last_step);
   assign verdict_fail = fail_seen_reg || (state_reg == ST_RUN && !step_pass); // see [RL22]
   assign any_key = KEY_ONOFF_I || KEY_TRIGGER_I || KEY_UP_I || KEY_DOWN_I || KEY_OTHER_I;
   assign fire_now = done_now && (FIRE_COND_I == auto_test_pkg::FIRE_ON_END
                                  || (FIRE_COND_I == auto_test_pkg::FIRE_ON_PASS && !verdict_fail)
                                  || (FIRE_COND_I == auto_test_pkg::FIRE_ON_FAIL && verdict_fail)); // see [RL13]

   // status flags and applied operating condition
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         LOADED_SEQUENCE_INDICATOR_O <= 1'b0;
         WAITING_STATUS_O <= 1'b0;
         SUSPENDED_STATUS_O <= 1'b0;
         MANUAL_STATUS_O <= 1'b0;
         APPLY_O <= '0;
      end else begin
         LOADED_SEQUENCE_INDICATOR_O <= loaded_reg;
         WAITING_STATUS_O <= (state_reg == ST_RUN); // see [RL17]
         SUSPENDED_STATUS_O <= (state_reg == ST_SUSPEND); // see [RL17]
         MANUAL_STATUS_O <= (state_reg == ST_MANUAL);
         if (state_reg == ST_IDLE) begin
            APPLY_O <= '0;
         end else begin
            APPLY_O <= step_apply(cur_step); // see [RL10] [RL19]
         end
      end
   end

   // verdict; a new completion wins over a clearing key in the same cycle
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         PASS_O <= 1'b0;
         FAIL_O <= 1'b0;
         ALARM_O <= 1'b0;
      end else if (done_now) begin
         PASS_O <= !verdict_fail; // see [RL12]
         FAIL_O <= verdict_fail;
         ALARM_O <= verdict_fail; // see [RL12]
      end else if (any_key || ext_trig_reg) begin
         PASS_O <= 1'b0; // see [RL18]
         FAIL_O <= 1'b0;
         ALARM_O <= 1'b0;
      end
   end

   // result signal line, level or timed style
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         RESULT_SIGNAL_OUTPUT_O <= auto_test_pkg::RESULT_OUT_RST;
         pulse_cnt_reg <= 8'h00;
      end else if (fire_now) begin
         RESULT_SIGNAL_OUTPUT_O <= 1'b1; // see [RL13]
         pulse_cnt_reg <= 8'h00;
      end else if (RESULT_SIGNAL_OUTPUT_O) begin
         if (TIMED_OUTPUT_STYLE_I) begin
            if (tick) begin
               if (pulse_cnt_reg == 8'(auto_test_pkg::PULSE_TICKS - 1)) begin
                  RESULT_SIGNAL_OUTPUT_O <= 1'b0; // see [RL15]
               end
               pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
            end
         end else if (any_key || ext_trig_reg) begin
            RESULT_SIGNAL_OUTPUT_O <= 1'b0; // see [RL14]
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence seq_low_window;
      !EXTERNAL_START_INPUT_N_I [*8];
   endsequence

   AST_STATUS_EXCLUSIVE: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // see [RL17]
      !(WAITING_STATUS_O && SUSPENDED_STATUS_O)) else $error("waiting and suspended both shown");
   AST_ALARM_WITH_FAIL: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // see [RL12]
      ALARM_O == FAIL_O) else $error("alarm not tied to fail");
   AST_TRIG_NEEDS_LOW: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // see [RL16]
      ext_trig_reg |-> $past(!EXTERNAL_START_INPUT_N_I)) else $error("trigger without low line");
   AST_SUSPEND_HOLDS: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // see [RL8]
      (state_reg == ST_SUSPEND && !trig_any) |=> state_reg == ST_SUSPEND) else $error("left suspend");
   AST_LEN_RANGE: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // see [RL2]
      (LEN_WE_I && !LIST_DEFINE_I && LEN_VALUE_I == 6'h00) |=> LEN_REJECT_O) else $error("zero length kept");
   AST_NEVER_FIRES: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // see [RL13]
      (FIRE_COND_I == auto_test_pkg::FIRE_NEVER && !RESULT_SIGNAL_OUTPUT_O) |=> !RESULT_SIGNAL_OUTPUT_O)
      else $error("output fired while disabled");
   AST_LEVEL_CLEARS: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // see [RL14]
      (RESULT_SIGNAL_OUTPUT_O && !TIMED_OUTPUT_STYLE_I && KEY_OTHER_I && !fire_now) |=> !RESULT_SIGNAL_OUTPUT_O)
      else $error("level output not cleared");
   AST_VERDICT_CLEARS: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // see [RL18]
      (KEY_OTHER_I && !done_now) |=> !PASS_O && !FAIL_O) else $error("verdict kept after key");
   AST_RESTART: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // see [RL20]
      (state_reg == ST_MANUAL && loaded_reg && KEY_ONOFF_I) |=> state_reg == ST_RUN && step_reg == 6'h00)
      else $error("manual mode did not restart");
   AST_LIST_ERASE: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // see [RL21]
      LIST_DEFINE_I |=> len_reg[$past(PROG_SLOT_I)] == 6'h00) else $error("slot not erased");
   AST_LOW_SEEN: cover property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) seq_low_window);

endmodule

/* File: testbench/load_source_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// source under test and rear trigger line
// ----------------------------------------
module load_source_model #(
   parameter int HOLD_CYCLES = 12
) (
   // stimulus from the bench
   input wire logic clk_i,
   input wire logic good_i,
   input wire logic trig_req_i,
   // load side
   input wire auto_test_pkg::apply_type apply_i,
   output auto_test_pkg::meas_type meas_o,
   output logic trig_n_o
);
   int low_cnt = 0; // cycles left with the line pulled low
   logic [15:0] lvl; // level seen on each quantity the mode does not zero
   // in-limit level when healthy, far above the upper limit otherwise
   assign lvl = good_i ? 16'h0100 : 16'h0F00;
   // an open input shows voltage but no current, a short the reverse,
   // so comparing the wrong quantity there makes the step fail
   always_comb begin
      meas_o = {lvl, lvl, lvl, lvl};
      if (apply_i.mode == auto_test_pkg::MODE_INPUT_OFF) begin
         meas_o.current = 16'h0000;
      end
      if (apply_i.mode == auto_test_pkg::MODE_SHORT_CIRCUIT) begin
         meas_o.voltage = 16'h0000;
      end
   end
   // line held low longer than the qualification time, then pulled up
   always @(posedge clk_i) begin
      if (trig_req_i) begin
         low_cnt <= HOLD_CYCLES;
      end else if (low_cnt > 0) begin
         low_cnt <= low_cnt - 1;
      end
   end
   assign trig_n_o = (low_cnt == 0);
endmodule

/* File: testbench/auto_test_step_sequencer_tb.sv */
`timescale 1ns/1ps
module auto_test_step_sequencer_tb;
   // ----------------------------------------
   // stimulus and observation
   // ----------------------------------------
   logic clk = 0, rst_n = 0, prog_we = 0, len_we = 0, list_def = 0, load = 0, timed = 0;
   logic k_on = 0, k_trg = 0, k_up = 0, k_dn = 0, k_oth = 0, good = 1, trig_req = 0, trig_n;
   logic [2:0] slot = 3'h3;
   logic [5:0] step_idx = 6'h00, len_val = 6'h00;
   logic [15:0] sp;
   auto_test_pkg::step_type prog_data = '0;
   auto_test_pkg::fire_cond_type fire = auto_test_pkg::FIRE_ON_PASS;
   auto_test_pkg::meas_type meas;
   auto_test_pkg::apply_type apply;
   logic rej, ind, wait_s, susp, man, pass, fail, alarm, res, seen = 0;
   logic [1:0] verdict_q[$]; // expected {pass, fail} per run
   int mismatches = 0, checks = 0;
   always #2.5 clk = ~clk;
   // short tick and qualification so a run takes about forty cycles
   auto_test_step_sequencer #(.TICK_CYCLES(10), .START_LOW_CYCLES(8)) auto_test_step_sequencer_i (
      .SYS_CLK_I(clk), .RESET_N_I(rst_n), .PROG_WE_I(prog_we), .PROG_SLOT_I(slot),
      .PROG_STEP_I(step_idx), .PROG_DATA_I(prog_data), .LEN_WE_I(len_we), .LEN_VALUE_I(len_val),
      .LIST_DEFINE_I(list_def), .LEN_REJECT_O(rej), .LOAD_SLOT_I(slot), .LOAD_I(load),
      .FIRE_COND_I(fire), .TIMED_OUTPUT_STYLE_I(timed), .KEY_ONOFF_I(k_on), .KEY_TRIGGER_I(k_trg),
      .KEY_UP_I(k_up), .KEY_DOWN_I(k_dn), .KEY_OTHER_I(k_oth), .EXTERNAL_START_INPUT_N_I(trig_n),
      .MEAS_I(meas), .APPLY_O(apply), .LOADED_SEQUENCE_INDICATOR_O(ind), .WAITING_STATUS_O(wait_s),
      .SUSPENDED_STATUS_O(susp), .MANUAL_STATUS_O(man), .PASS_O(pass), .FAIL_O(fail),
      .ALARM_O(alarm), .RESULT_SIGNAL_OUTPUT_O(res));
   load_source_model load_source_model_i (.clk_i(clk), .good_i(good), .trig_req_i(trig_req),
      .apply_i(apply), .meas_o(meas), .trig_n_o(trig_n));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // inputs always move one ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      tick(1);
      s = 0;
   endtask
   task automatic wr(input logic [5:0] i, input auto_test_pkg::step_type d);
      step_idx = i;
      prog_data = d;
      pulse(prog_we);
      tick(1);
   endtask
   task automatic setlen(input logic [5:0] n, input logic e);
      len_val = n;
      pulse(len_we);
      chk("len_reject", e, rej);
      tick(1);
   endtask
   // bounded wait on 0 waiting, 1 suspended, 2 any verdict
   task automatic wait_for(input int c, input string n);
      for (int i = 0; i < 3000 && (c == 0 ? wait_s : c == 1 ? susp : pass | fail) !== 1'b1; i++) tick(1);
      chk(n, 1, c == 0 ? wait_s : c == 1 ? susp : pass | fail);
      tick(1);
   endtask
   task automatic give_verdict;
      chk("pending", 0, verdict_q.size());
      if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // verdict monitor: oldest note per new result
   // ----------------------------------------
   always @(negedge clk) begin
      if ((pass | fail) === 1'b1 && seen === 1'b0) begin
         chk("verdict", verdict_q.size() ? verdict_q[0] : 2'b00, {pass, fail});
         chk("alarm", verdict_q.size() ? verdict_q[0][0] : 1'b1, alarm);
         if (verdict_q.size()) void'(verdict_q.pop_front());
      end
      seen <= pass | fail;
   end
   // hang guard well past the expected run length
   initial begin
      #100000;
      mismatches++;
      give_verdict();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(1086));
      sp = 16'($urandom);
      slot = 3'($urandom);
      tick(20);
      rst_n = 1;
      setlen(0, 1);
      setlen(51, 1);
      setlen(3, 0);
      // regulated step, open step, shorted step with ignored kinds
      wr(0, '{auto_test_pkg::MODE_CONSTANT_CURRENT, auto_test_pkg::CMP_CURRENT, 8'h01, sp, 16'h0080, 16'h0200});
      wr(1, '{auto_test_pkg::MODE_INPUT_OFF, auto_test_pkg::CMP_CURRENT, 8'h02, 16'h0000, 16'h0080, 16'h0200});
      wr(2, '{auto_test_pkg::MODE_SHORT_CIRCUIT, auto_test_pkg::CMP_VOLTAGE, 8'h01, 16'h0, 16'h0080, 16'h0200});
      pulse(load);
      tick(2);
      chk("indicator", 1, ind);
      // passing run started from the key, level style output
      verdict_q.push_back(2'b10);
      pulse(k_on);
      wait_for(0, "waiting");
      chk("apply", {auto_test_pkg::MODE_CONSTANT_CURRENT, sp}, apply);
      wait_for(2, "done");
      chk("fire_pass", 1, res);
      pulse(k_oth);
      tick(2);
      chk("cleared", 3'b000, {pass, fail, res});
      // failing run from the rear trigger, timed output
      good = 0;
      fire = auto_test_pkg::FIRE_ON_FAIL;
      timed = 1;
      verdict_q.push_back(2'b01);
      pulse(trig_req);
      wait_for(2, "done_fail");
      chk("fire_fail", 1, res);
      tick(400);
      chk("timed_high", 1, res);
      tick(120);
      chk("timed_low", 0, res);
      // manual stepping back and forth from the last step
      pulse(k_up);
      tick(2);
      chk("manual", 3'b100, {man, pass, fail});
      chk("manual_up", auto_test_pkg::MODE_INPUT_OFF, apply.mode);
      pulse(k_up);
      tick(2);
      chk("manual_up2", {auto_test_pkg::MODE_CONSTANT_CURRENT, sp}, apply);
      pulse(k_dn);
      tick(2);
      chk("manual_step", auto_test_pkg::MODE_INPUT_OFF, apply.mode);
      // on/off leaves manual mode and restarts from the first step
      good = 1;
      fire = auto_test_pkg::FIRE_ON_END;
      timed = 0;
      verdict_q.push_back(2'b10);
      pulse(k_on);
      wait_for(0, "restart");
      chk("restart_mode", {1'b0, auto_test_pkg::MODE_CONSTANT_CURRENT}, {man, apply.mode});
      wait_for(2, "done_end");
      chk("fire_end", 1, res);
      // suspended middle step resumed by the trigger key
      wr(1, '{auto_test_pkg::MODE_INPUT_OFF, auto_test_pkg::CMP_VOLTAGE, 8'hFF, 16'h0, 16'h0080, 16'h0200});
      verdict_q.push_back(2'b10);
      pulse(k_on);
      wait_for(1, "suspended");
      tick(60);
      chk("still_suspended", 2'b10, {susp, wait_s});
      pulse(k_trg);
      wait_for(2, "resumed");
      // list redefinition empties the slot, so a start is refused
      pulse(list_def);
      pulse(load);
      pulse(k_on);
      tick(20);
      chk("erased", {3'b000, auto_test_pkg::MODE_SHORT_CIRCUIT, 16'h0000}, {wait_s, susp, ind, apply});
      give_verdict();
   end
endmodule
